/* File: rtl/lar_top.sv */
// Serial register front end: low alarm limit bytes and previous command echo
// Functional notes
// - Each channel low-limit low byte is read/write, lowest limit byte, resets zero.
// - Channel 0 limit is byte at 18h above byte at 19h.
// - One low byte register per channel: eight or four channels.
// - Reading 3Fh returns the command executed in the previous frame.
// - Echo shifts out MSB first from the 16th falling serial clock edge.
// - Only eight echo bits carry data; the next eight are zeros.
// - Echo register: eight bits, read-only, reset zero, command bits 15:8.
`timescale 1ns/10ps
`default_nettype none
`include "lar_defs.svh"

module lar_top import lar_pkg::*; #(
  parameter int unsigned NCH = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic frame_sel_n,
  input wire logic ser_clk,
  input wire logic ser_din,
  output logic ser_dout,
  output logic ser_dout_oe,
  output logic [NCH*16-1:0] chan_low_limit
);

  lar_state_t s;
  lar_state_t n;
  lar_rb_if rb ();

  logic rise;
  logic fall;
  logic exec;
  logic [15:0] cmd_full;
  lar_byte_t rd_byte;

  // ==========================================================
  // Frame logic
  always_comb begin
    n = s;
    // First stage only feeds the second; the filter looks at stages two and three
    n.cs_sync = {s.cs_sync[1:0], frame_sel_n};
    n.sck_sync = {s.sck_sync[1:0], ser_clk};
    n.sdi_sync = {s.sdi_sync[1:0], ser_din};
    n.cs_f = (s.cs_sync[1] == s.cs_sync[2]) ? s.cs_sync[2] : s.cs_f;
    n.sck_f = (s.sck_sync[1] == s.sck_sync[2]) ? s.sck_sync[2] : s.sck_f;
    n.sdi_f = (s.sdi_sync[1] == s.sdi_sync[2]) ? s.sdi_sync[2] : s.sdi_f;
    rise = n.sck_f && !s.sck_f && !s.cs_f;
    fall = !n.sck_f && s.sck_f && !s.cs_f;
    cmd_full = {s.cmd[14:0], n.sdi_f};
    exec = rise && s.rise_cnt == `LAR_CMD_LAST_RISE;
    rd_byte = s.echo_sel ? s.echo_hold : rb.rdata;
    n.rb_wr = 1'b0;
    n.rb_rd = 1'b0;
    if (s.cs_f) begin
      n.rise_cnt = 6'h00;
      n.fall_cnt = 6'h00;
      n.sdo = 1'b0;
      n.sdo_oe = 1'b0;
    end else begin
      n.sdo_oe = 1'b1;
      if (rise) begin
        if (s.rise_cnt != `LAR_EDGE_MAX) begin
          n.rise_cnt = s.rise_cnt + 6'h01;
        end
        if (s.rise_cnt <= `LAR_CMD_LAST_RISE) begin
          n.cmd = cmd_full;
        end
      end
      if (exec) begin
        n.rb_addr = cmd_full[15:9];
        n.rb_wdata = cmd_full[7:0];
        n.echo_sel = (cmd_full[15:9] == `LAR_ECHO_ADDR);
        // Hold the previous frame's command before the echo takes this one
        n.echo_hold = s.echo;
        n.rb_rd = 1'b1;
        n.rb_wr = cmd_full[8] && (cmd_full[15:9] != `LAR_ECHO_ADDR);
        n.echo = cmd_full[15:8];
      end
      if (fall) begin
        if (s.fall_cnt != `LAR_EDGE_MAX) begin
          n.fall_cnt = s.fall_cnt + 6'h01;
        end
        if (s.fall_cnt == `LAR_ECHO_FIRST_FALL) begin
          n.dout_sh = {rd_byte, 8'h00};
          n.sdo = rd_byte[7];
        end else if (s.fall_cnt > `LAR_ECHO_FIRST_FALL) begin
          n.dout_sh = {s.dout_sh[14:0], 1'b0};
          n.sdo = s.dout_sh[14];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.cs_sync <= 3'h7;
      s.cs_f <= 1'b1;
      s.echo <= `LAR_ECHO_RESET;
      s.echo_hold <= `LAR_ECHO_RESET;
    end else begin
      s <= n;
    end
  end

  assign rb.wr = s.rb_wr;
  assign rb.rd = s.rb_rd;
  assign rb.addr = s.rb_addr;
  assign rb.wdata = s.rb_wdata;
  assign ser_dout = s.sdo;
  assign ser_dout_oe = s.sdo_oe;

  // ==========================================================
  // Limit storage
  lar_thr_bank #(
    .NCH(NCH)
  ) u_bank (
    .sys_clk(sys_clk),
    .reset(reset),
    .rb(rb.bank),
    .chan_low_limit(chan_low_limit)
  );

  // ==========================================================
  // Checks
  echo_capture_a: assert property (@(posedge sys_clk) disable iff (reset)
    exec |=> s.echo == $past(cmd_full[15:8]) ##1 s.echo == $past(s.echo))
    else $error("echo did not capture executed command");
  echo_previous_a: assert property (@(posedge sys_clk) disable iff (reset)
    exec && cmd_full[15:9] == `LAR_ECHO_ADDR |=> s.echo_sel && s.echo_hold == $past(s.echo) && !s.rb_wr)
    else $error("echo read does not return previous command");
  sdo_quiet_a: assert property (@(posedge sys_clk) disable iff (reset)
    s.fall_cnt <= `LAR_ECHO_FIRST_FALL |-> !s.sdo)
    else $error("data driven before 16th falling edge");
  echo_msb_a: assert property (@(posedge sys_clk) disable iff (reset)
    fall && s.fall_cnt == `LAR_ECHO_FIRST_FALL |=> s.sdo == $past(rd_byte[7]) && s.fall_cnt == 6'h10)
    else $error("first echo bit is not the MSB");
  zero_tail_a: assert property (@(posedge sys_clk) disable iff (reset)
    s.fall_cnt >= `LAR_ECHO_ZERO_FALL |-> !s.sdo)
    else $error("trailing echo bits not zero");
  write_issue_a: assert property (@(posedge sys_clk) disable iff (reset)
    exec && cmd_full[8] && cmd_full[15:9] == `LAR_LT_LSB_CH0 |=> s.rb_wr ##1 !s.rb_wr)
    else $error("write of a limit byte not issued once");

  echo_read_c: cover property (@(posedge sys_clk) disable iff (reset)
    exec && cmd_full[15:9] == `LAR_ECHO_ADDR ##[1:600] fall && s.fall_cnt == `LAR_ECHO_ZERO_FALL);
  lsb_write_c: cover property (@(posedge sys_clk) disable iff (reset)
    exec && cmd_full[8] && cmd_full[15:9] == `LAR_LT_LSB_CH0);
  aborted_frame_c: cover property (@(posedge sys_clk) disable iff (reset)
    s.rise_cnt == 6'h08 && n.cs_f);

endmodule : lar_top

`default_nettype wire

/* File: rtl/lar_defs.svh */
// Register map, frame positions and reset values of the low-limit and echo register block
`ifndef LAR_DEFS_SVH
`define LAR_DEFS_SVH

// ==========================================================
// Register map
`define LAR_LT_MSB_CH0 7'h18
`define LAR_LT_LSB_CH0 7'h19
`define LAR_CH_STRIDE 7'h05
`define LAR_ECHO_ADDR 7'h3F

// ==========================================================
// Reset values
`define LAR_LT_RESET 8'h00
`define LAR_ECHO_RESET 8'h00

// ==========================================================
// Frame positions, counted in serial clock edges
`define LAR_CMD_LAST_RISE 6'h0F
`define LAR_ECHO_FIRST_FALL 6'h0F
`define LAR_ECHO_ZERO_FALL 6'h18
`define LAR_EDGE_MAX 6'h3F

`endif

/* File: rtl/lar_pkg.sv */
// Shared types of the low-limit and echo register block
package lar_pkg;

  typedef logic [6:0] lar_addr_t;
  typedef logic [7:0] lar_byte_t;

  // ==========================================================
  // Serial front end and frame state
  typedef struct packed {
    logic [2:0] cs_sync;
    logic [2:0] sck_sync;
    logic [2:0] sdi_sync;
    logic cs_f;
    logic sck_f;
    logic sdi_f;
    logic [5:0] rise_cnt;
    logic [5:0] fall_cnt;
    logic [15:0] cmd;
    logic [15:0] dout_sh;
    logic echo_sel;
    lar_byte_t echo;
    lar_byte_t echo_hold;
    logic rb_wr;
    logic rb_rd;
    lar_addr_t rb_addr;
    lar_byte_t rb_wdata;
    logic sdo;
    logic sdo_oe;
  } lar_state_t;

  // Byte address of a channel's low-limit byte
  function automatic lar_addr_t lar_lt_addr(input int unsigned ch, input logic msb);
    int unsigned a;
    a = (msb ? 32'h18 : 32'h19) + ch * 32'h5;
    return a[6:0];
  endfunction : lar_lt_addr

endpackage : lar_pkg

/* File: rtl/lar_rb_if.sv */
// Internal register access path between the serial front end and the limit bank
`timescale 1ns/10ps
`default_nettype none

interface lar_rb_if;
  import lar_pkg::*;
  logic wr;
  logic rd;
  lar_addr_t addr;
  lar_byte_t wdata;
  lar_byte_t rdata;

  modport master (output wr, output rd, output addr, output wdata, input rdata);
  modport bank (input wr, input rd, input addr, input wdata, output rdata);
endinterface : lar_rb_if

`default_nettype wire

/* File: rtl/lar_thr_bank.sv */
// Per-channel 16-bit low alarm limit storage with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "lar_defs.svh"

module lar_thr_bank import lar_pkg::*; #(
  parameter int unsigned NCH = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  lar_rb_if.bank rb,
  output logic [NCH*16-1:0] chan_low_limit
);

  typedef struct packed {
    logic [NCH-1:0][7:0] msb;
    logic [NCH-1:0][7:0] lsb;
    lar_byte_t rdata;
  } lar_bank_t;

  lar_bank_t b_r;
  lar_bank_t b_nxt;
  logic [NCH-1:0] hit_msb;
  logic [NCH-1:0] hit_lsb;

  // ==========================================================
  // Address decode, one pair per channel
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_dec
      assign hit_msb[gi] = (rb.addr == lar_lt_addr(gi, 1'b1));
      assign hit_lsb[gi] = (rb.addr == lar_lt_addr(gi, 1'b0));
      assign chan_low_limit[gi*16 +: 16] = {b_r.msb[gi], b_r.lsb[gi]};
    end
  endgenerate

  always_comb begin
    b_nxt = b_r;
    for (int n = 0; n < NCH; n++) begin
      if (rb.wr && hit_msb[n]) begin
        b_nxt.msb[n] = rb.wdata;
      end
      if (rb.wr && hit_lsb[n]) begin
        b_nxt.lsb[n] = rb.wdata;
      end
    end
    // Read returns the old value when read and write meet in one cycle
    if (rb.rd) begin
      b_nxt.rdata = 8'h00;
      for (int n = 0; n < NCH; n++) begin
        if (hit_msb[n]) begin
          b_nxt.rdata = b_r.msb[n];
        end
        if (hit_lsb[n]) begin
          b_nxt.rdata = b_r.lsb[n];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      b_r.msb <= {NCH{`LAR_LT_RESET}};
      b_r.lsb <= {NCH{`LAR_LT_RESET}};
      b_r.rdata <= 8'h00;
    end else begin
      b_r <= b_nxt;
    end
  end

  assign rb.rdata = b_r.rdata;

  // ==========================================================
  // Checks
  lsb_write_a: assert property (@(posedge sys_clk) disable iff (reset)
    rb.wr && rb.addr == `LAR_LT_LSB_CH0 |=> chan_low_limit[7:0] == $past(rb.wdata))
    else $error("low byte of channel 0 limit not written");
  msb_concat_a: assert property (@(posedge sys_clk) disable iff (reset)
    rb.wr && rb.addr == `LAR_LT_MSB_CH0 |=> chan_low_limit[15:8] == $past(rb.wdata)
      && chan_low_limit[7:0] == $past(chan_low_limit[7:0]))
    else $error("channel 0 limit high byte misplaced");
  last_chan_a: assert property (@(posedge sys_clk) disable iff (reset)
    rb.wr && rb.addr == lar_lt_addr(NCH-1, 1'b0) |=> chan_low_limit[(NCH-1)*16 +: 8] == $past(rb.wdata))
    else $error("last channel low byte not written");
  limit_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    !rb.wr |=> $stable(chan_low_limit))
    else $error("limit changed without a write");
  lsb_read_a: assert property (@(posedge sys_clk) disable iff (reset)
    rb.rd && rb.addr == `LAR_LT_LSB_CH0 |=> rb.rdata == $past(chan_low_limit[7:0]))
    else $error("channel 0 low byte read back wrong");

endmodule : lar_thr_bank

`default_nettype wire

/* File: test/lar_host_model.sv */
// Serial host model that frames commands into the register block
`timescale 1ns/10ps
`default_nettype none

module lar_host_model (
  input wire logic sys_clk,
  output logic frame_sel_n,
  output logic ser_clk,
  output logic ser_din,
  input wire logic ser_dout
);
  initial begin
    frame_sel_n = 1'b1;
    ser_clk = 1'b0;
    ser_din = 1'b0;
  end

  // ==========================================================
  // One frame of n serial clocks, each half period 4 system clocks
  task automatic xfer(input logic [15:0] word, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    @(negedge sys_clk);
    frame_sel_n <= 1'b0;
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < n; i++) begin
      // Bits past the command toggle so stale data never looks valid
      ser_din <= (i < 16) ? word[15 - i] : ~ser_din;
      repeat (4) @(negedge sys_clk);
      ser_clk <= 1'b1;
      repeat (4) @(negedge sys_clk);
      // Sample just before the next fall, long after the last one settled
      if (i >= 16) rd[31 - i] = ser_dout;
      ser_clk <= 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    frame_sel_n <= 1'b1;
    ser_din <= ~ser_din;
    repeat (6) @(negedge sys_clk);
  endtask : xfer
endmodule : lar_host_model

`default_nettype wire

/* File: test/lar_top_tb_top.sv */
// Self-checking bench for the low-limit and echo register block
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, ev, got) begin comparisons++; if ((got) !== (ev)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", nm, ev, got); end end

module lar_top_tb_top;
  localparam int NCH = 8;
  logic sys_clk, reset, frame_sel_n, ser_clk, ser_din, ser_dout, ser_dout_oe;
  logic [NCH*16-1:0] chan_low_limit;
  logic [15:0] rd;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int mem [128] = '{default: 0};
  int echo = 0;
  int oe_cycles = 0;

  // Counts cycles with the output enabled, so every frame shows how long the pin was driven
  always @(negedge sys_clk) begin
    if (ser_dout_oe === 1'b1) oe_cycles++;
  end

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  lar_top #(.NCH(NCH)) dut (.sys_clk(sys_clk), .reset(reset), .frame_sel_n(frame_sel_n), .ser_clk(ser_clk),
    .ser_din(ser_din), .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe), .chan_low_limit(chan_low_limit));
  lar_host_model host (.sys_clk(sys_clk), .frame_sel_n(frame_sel_n), .ser_clk(ser_clk), .ser_din(ser_din),
    .ser_dout(ser_dout));

  // ==========================================================
  // Reference model
  function automatic bit mapped(input int a);
    for (int c = 0; c < NCH; c++) begin
      if (a == 32'h18 + 5 * c || a == 32'h19 + 5 * c) return 1'b1;
    end
    return 1'b0;
  endfunction : mapped

  task automatic check_limits();
    for (int c = 0; c < NCH; c++) begin
      `CHK("limit", {mem[32'h18 + 5 * c][7:0], mem[32'h19 + 5 * c][7:0]}, chan_low_limit[c*16+:16])
    end
  endtask : check_limits

  // Short frames are dropped by the device, so the model keeps its state
  task automatic run(input int addr, input bit wr, input int data, input int n);
    int ev;
    logic [15:0] w;
    w = {addr[6:0], wr, data[7:0]};
    ev = (addr == 32'h3F) ? echo : (mapped(addr) ? mem[addr] : 0);
    oe_cycles = 0;
    host.xfer(w, n, rd);
    `CHK("oe cycles", 8 * n + 8, oe_cycles)
    `CHK("dout idle", 1'b0, ser_dout)
    if (n >= 16) begin
      `CHK("read data", {ev[7:0], 8'h00}, rd)
      if (wr && mapped(addr)) mem[addr] = data[7:0];
      echo = w[15:8];
    end
    check_limits();
  endtask : run

  task automatic wrap_up();
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    reset = 1'b1;
    repeat (10) @(negedge sys_clk);
    reset <= 1'b0;
    void'($urandom(32'hCCA7));
    repeat (2) @(negedge sys_clk);
    `CHK("oe idle", 1'b0, ser_dout_oe)
    check_limits();
    run(32'h3F, 1'b0, 0, 32);
    run(32'h19, 1'b1, 32'hFF, 32);
    run(32'h3F, 1'b0, 0, 24);
    run(32'h3F, 1'b0, 0, 32);
    for (int c = 0; c < NCH; c++) begin
      run(32'h18 + 5 * c, 1'b1, $urandom_range(0, 255), 32);
      run(32'h19 + 5 * c, 1'b1, $urandom_range(0, 255), 32);
      run(32'h19 + 5 * c, 1'b0, 0, 32);
    end
    // Second reset in mid-run: every limit byte and the echo must return to zero
    @(negedge sys_clk);
    reset <= 1'b1;
    repeat (3) @(negedge sys_clk);
    reset <= 1'b0;
    mem = '{default: 0};
    echo = 0;
    repeat (2) @(negedge sys_clk);
    `CHK("oe after reset", 1'b0, ser_dout_oe)
    check_limits();
    run(32'h3F, 1'b0, 0, 32);
    run(32'h3F, 1'b1, 32'hAA, 32);
    run(32'h3F, 1'b0, 0, 32);
    run(32'h19, 1'b1, 32'h5A, 10);
    run(32'h3F, 1'b0, 0, 32);
    for (int k = 0; k < 30; k++) begin
      run($urandom_range(0, 127), 1'($urandom_range(0, 1)), $urandom_range(0, 255), 32);
    end
    wrap_up();
  end
endmodule : lar_top_tb_top

`default_nettype wire
